// ### sbg_pkg.sv
package sbg_pkg;
	// standby modes seen by the gating logic
	typedef enum logic [2:0] {
		SBG_RUN = 3'b000,
		SBG_HALT = 3'b001,
		SBG_HALT_H = 3'b010,
		SBG_HALT_D = 3'b011,
		SBG_STOP = 3'b100,
		SBG_STOP_D = 3'b101
	} sbg_mode_t;

	// register word offsets (byte addresses, one word each)
	localparam logic [5:0] SBG_OFF_CKS0 = 6'h00;
	localparam logic [5:0] SBG_OFF_CKS1 = 6'h04;
	localparam logic [5:0] SBG_OFF_CKS2 = 6'h08;
	localparam logic [5:0] SBG_OFF_CKS3 = 6'h0C;
	localparam logic [5:0] SBG_OFF_RST0 = 6'h10;
	localparam logic [5:0] SBG_OFF_RST1 = 6'h14;
	localparam logic [5:0] SBG_OFF_RST2 = 6'h18;
	localparam logic [5:0] SBG_OFF_RST3 = 6'h1C;
	localparam logic [5:0] SBG_OFF_SWRST = 6'h20;
	localparam logic [5:0] SBG_OFF_MODE = 6'h24;
	localparam logic [5:0] SBG_OFF_PLLWU = 6'h28;
	localparam logic [5:0] SBG_OFF_STAT = 6'h2C;

	// field positions and reset values
	localparam int SBG_NPERIPH = 32;
	localparam int SBG_MODE_LSB = 0;
	localparam int SBG_VFIX_BIT = 4;
	localparam logic [7:0] SBG_GATE_RST = 8'hFF;
	localparam logic [7:0] SBG_PLLWU_RAMP = 8'h01;
	localparam logic [7:0] SBG_PLLWU_RST = 8'h00;
	// bit 20 of the flat vector is UART peripherals range start
	localparam int SBG_UART_LO = 20;
	localparam int SBG_UART_HI = 22;

	// regulator level codes
	localparam logic [1:0] SBG_V155 = 2'h2;
	localparam logic [1:0] SBG_V145 = 2'h1;
	localparam logic [1:0] SBG_V115 = 2'h0;

	// timings
	localparam int SBG_CLK_MHZ = 100;
	localparam int SBG_PLL_RAMP_US = 2000;
	localparam int SBG_WAKE_HALT_US = 60;
	localparam int SBG_WAKE_HALTD_US = 300;
	localparam int SBG_WAKE_STOP_US = 3000;
	localparam int SBG_PLL_RAMP_CYC = SBG_PLL_RAMP_US * SBG_CLK_MHZ;
	localparam int SBG_WAKE_HALT_CYC = SBG_WAKE_HALT_US * SBG_CLK_MHZ;
	localparam int SBG_WAKE_HALTD_CYC = SBG_WAKE_HALTD_US * SBG_CLK_MHZ;
	localparam int SBG_WAKE_STOP_CYC = SBG_WAKE_STOP_US * SBG_CLK_MHZ;
endpackage

// ### sbg_gating.sv
// Design decisions made here: the register offsets and the Avalon-MM slave port.
`timescale 1ns/100ps
module sbg_gating
	import sbg_pkg::*;
#(
	parameter int PLL_RAMP_CYC = SBG_PLL_RAMP_CYC,
	parameter int WAKE_HALT_CYC = SBG_WAKE_HALT_CYC,
	parameter int WAKE_HALTD_CYC = SBG_WAKE_HALTD_CYC,
	parameter int WAKE_STOP_CYC = SBG_WAKE_STOP_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// avalon-mm slave
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// peripheral register access check
	input wire logic [4:0] per_sel,
	input wire logic per_write,
	input wire logic per_read,
	output logic per_write_ok,
	output logic per_read_ok,
	// wake events from pins
	input wire logic wake_pin,
	input wire logic i2c_addr_match,
	// gating outputs
	output logic [31:0] per_clk_en,
	output logic [31:0] per_rst,
	output logic port_cfg_rst,
	output logic pll_run,
	output logic lsosc_run,
	output logic keep_wdt_ltb,
	output logic keep_vls,
	output logic keep_fast_periph,
	output logic smp_fast_dis,
	output logic smp_all_dis,
	output logic i2c_wake_en,
	output logic [1:0] core_supply_voltage,
	output logic cpu_clk_ready
);
	// register state
	logic [31:0] cks_q;
	logic [31:0] rst_q;
	logic swrst_q;
	logic [2:0] mode_q;
	logic vfix_q;
	logic [7:0] pllwu_q;
	logic ran_q;
	logic ack_q;
	logic [31:0] wake_cnt_q;
	logic waking_q;
	logic [1:0] wake_sync_q;
	logic [1:0] i2c_sync_q;
	sbg_mode_t mode_e;
	logic deep_v;
	logic stopm;

	assign mode_e = sbg_mode_t'(mode_q);
	assign stopm = (mode_e == SBG_STOP) || (mode_e == SBG_STOP_D);
	assign deep_v = (mode_e == SBG_HALT_D) || (mode_e == SBG_STOP_D);

	// one wait cycle per access, answer on the second edge
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= (avs_read || avs_write) && !ack_q;
		end
	end
	assign avs_waitrequest = (avs_read || avs_write) && !ack_q;

	// pair registers, byte per peripheral group
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cks_q <= {4{SBG_GATE_RST}};
			rst_q <= {4{SBG_GATE_RST}};
		end else if (avs_write && ack_q) begin
			if (avs_address == SBG_OFF_CKS0) begin
				cks_q[7:0] <= avs_writedata[7:0];
			end else if (avs_address == SBG_OFF_CKS1) begin
				cks_q[15:8] <= avs_writedata[7:0];
			end else if (avs_address == SBG_OFF_CKS2) begin
				cks_q[23:16] <= avs_writedata[7:0];
			end else if (avs_address == SBG_OFF_CKS3) begin
				cks_q[31:24] <= avs_writedata[7:0];
			end else if (avs_address == SBG_OFF_RST0) begin
				rst_q[7:0] <= avs_writedata[7:0];
			end else if (avs_address == SBG_OFF_RST1) begin
				rst_q[15:8] <= avs_writedata[7:0];
			end else if (avs_address == SBG_OFF_RST2) begin
				rst_q[23:16] <= avs_writedata[7:0];
			end else if (avs_address == SBG_OFF_RST3) begin
				rst_q[31:24] <= avs_writedata[7:0];
			end
		end
	end

	// software reset pulse, mode request and options
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			swrst_q <= 1'b0;
			mode_q <= SBG_RUN;
			vfix_q <= 1'b0;
			pllwu_q <= SBG_PLLWU_RST;
		end else begin
			swrst_q <= avs_write && ack_q && (avs_address == SBG_OFF_SWRST)
				&& avs_writedata[0];
			if (waking_q && wake_cnt_q == 32'h0 && mode_q != SBG_RUN) begin
				mode_q <= SBG_RUN;
			end else if (avs_write && ack_q && avs_address == SBG_OFF_MODE) begin
				mode_q <= avs_writedata[SBG_MODE_LSB +: 3];
				vfix_q <= avs_writedata[SBG_VFIX_BIT];
			end else if (avs_write && ack_q && avs_address == SBG_OFF_PLLWU) begin
				pllwu_q <= avs_writedata[7:0];
			end
		end
	end

	// read mux
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			avs_readdata <= 32'h0;
		end else if (avs_read && !ack_q) begin
			if (avs_address[5:4] == 2'b00) begin
				avs_readdata <= {24'h0, cks_q[avs_address[3:2]*8 +: 8]};
			end else if (avs_address[5:4] == 2'b01) begin
				avs_readdata <= {24'h0, rst_q[avs_address[3:2]*8 +: 8]};
			end else if (avs_address == SBG_OFF_MODE) begin
				avs_readdata <= {27'h0, vfix_q, 1'b0, mode_q};
			end else if (avs_address == SBG_OFF_PLLWU) begin
				avs_readdata <= {24'h0, pllwu_q};
			end else if (avs_address == SBG_OFF_STAT) begin
				avs_readdata <= {26'h0, waking_q, cpu_clk_ready, ran_q, pll_run,
					core_supply_voltage};
			end else begin
				avs_readdata <= 32'h0;
			end
		end
	end

	// pin synchronisers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wake_sync_q <= 2'b00;
			i2c_sync_q <= 2'b00;
		end else begin
			wake_sync_q <= {wake_sync_q[0], wake_pin};
			i2c_sync_q <= {i2c_sync_q[0], i2c_addr_match};
		end
	end

	// wake-up timer; i2c match wakes only when enabled
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			waking_q <= 1'b0;
			wake_cnt_q <= 32'h0;
			cpu_clk_ready <= 1'b1;
		end else if (!waking_q && mode_q != SBG_RUN &&
			(wake_sync_q[1] || (i2c_sync_q[1] && i2c_wake_en))) begin
			waking_q <= 1'b1;
			cpu_clk_ready <= 1'b0;
			if (stopm) begin
				wake_cnt_q <= 32'(WAKE_STOP_CYC - 1);
			end else if (mode_e == SBG_HALT_D) begin
				wake_cnt_q <= 32'(WAKE_HALTD_CYC - 1);
			end else if (pllwu_q == SBG_PLLWU_RAMP && mode_e == SBG_HALT_H) begin
				wake_cnt_q <= 32'(PLL_RAMP_CYC - 1);
			end else begin
				wake_cnt_q <= 32'(WAKE_HALT_CYC - 1);
			end
		end else if (waking_q) begin
			if (wake_cnt_q == 32'h0) begin
				waking_q <= 1'b0;
				cpu_clk_ready <= 1'b1;
			end else begin
				wake_cnt_q <= wake_cnt_q - 32'h1;
			end
		end else if (mode_q != SBG_RUN) begin
			cpu_clk_ready <= 1'b0;
		end else begin
			cpu_clk_ready <= 1'b1;
		end
	end

	// peripheral clock/reset outputs; enables follow the gate registers in every mode
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			per_clk_en <= 32'h0;
			per_rst <= {32{1'b1}};
			port_cfg_rst <= 1'b1;
		end else begin
			per_clk_en <= ~cks_q;
			per_rst <= rst_q | {32{swrst_q}};
			port_cfg_rst <= swrst_q;
		end
	end

	// access qualification for peripheral registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			per_write_ok <= 1'b0;
			per_read_ok <= 1'b0;
		end else begin
			per_write_ok <= per_write && !cks_q[per_sel] && !rst_q[per_sel];
			if (per_sel >= 5'(SBG_UART_LO) && per_sel <= 5'(SBG_UART_HI)) begin
				per_read_ok <= per_read && !cks_q[per_sel] && !rst_q[per_sel];
			end else begin
				per_read_ok <= per_read;
			end
		end
	end

	// oscillator and function keep-alive per mode
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pll_run <= 1'b1;
			lsosc_run <= 1'b1;
			keep_wdt_ltb <= 1'b1;
			keep_vls <= 1'b1;
			keep_fast_periph <= 1'b1;
			smp_fast_dis <= 1'b0;
			smp_all_dis <= 1'b0;
			i2c_wake_en <= 1'b0;
		end else begin
			pll_run <= (mode_e == SBG_RUN) || (mode_e == SBG_HALT);
			lsosc_run <= !stopm;
			keep_wdt_ltb <= !stopm;
			keep_vls <= 1'b1;
			keep_fast_periph <= (mode_e == SBG_RUN) || (mode_e == SBG_HALT)
				|| (mode_e == SBG_HALT_H);
			smp_fast_dis <= (mode_e == SBG_HALT_H) || (mode_e == SBG_HALT_D)
				|| stopm;
			smp_all_dis <= stopm;
			i2c_wake_en <= (mode_e == SBG_HALT_D) || stopm;
		end
	end

	// core regulator level
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ran_q <= 1'b0;
			core_supply_voltage <= SBG_V155;
		end else begin
			ran_q <= 1'b1;
			if (deep_v) begin
				core_supply_voltage <= SBG_V115;
			end else if (vfix_q || !ran_q) begin
				core_supply_voltage <= SBG_V155;
			end else begin
				core_supply_voltage <= SBG_V145;
			end
		end
	end
endmodule // sbg_gating

// ### sbg_gating_chk.sv
`timescale 1ns/100ps
module sbg_gating_chk
	import sbg_pkg::*;
(
	// clock, reset and bus handshake
	input wire logic clk,
	input wire logic rst,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	// peripheral access check
	input wire logic [4:0] per_sel,
	input wire logic per_write,
	input wire logic per_read,
	input wire logic per_write_ok,
	input wire logic per_read_ok,
	// gating outputs
	input wire logic [31:0] per_clk_en,
	input wire logic [31:0] per_rst,
	input wire logic pll_run,
	input wire logic lsosc_run,
	input wire logic keep_wdt_ltb,
	input wire logic keep_fast_periph,
	input wire logic smp_all_dis,
	input wire logic i2c_wake_en,
	input wire logic [1:0] core_supply_voltage
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// target peripheral is clocked and out of reset
	wire live = per_clk_en[per_sel] && !per_rst[per_sel];
	wire uart = per_sel >= SBG_UART_LO && per_sel <= SBG_UART_HI;
	sequence s_req; $rose(avs_read | avs_write); endsequence
	sequence s_one_wait; avs_waitrequest ##1 !avs_waitrequest; endsequence
	a_bus_one_wait: assert property (s_req |-> s_one_wait) else $error("wait state count wrong");
	a_reset_all_off: assert property ($past(rst) |-> per_clk_en == 32'h0 && &per_rst)
		else $error("peripherals not disabled after reset");
	a_write_gate: assert property (per_write |=> per_write_ok == $past(live))
		else $error("write gating wrong");
	a_uart_read: assert property (per_read && uart |=> per_read_ok == $past(live))
		else $error("uart read gating wrong");
	a_other_read: assert property (per_read && !uart |=> per_read_ok)
		else $error("non-uart read blocked");
	a_pll_light: assert property (pll_run |-> lsosc_run && keep_fast_periph)
		else $error("pll running in deep mode");
	a_ls_keep: assert property (keep_wdt_ltb == lsosc_run)
		else $error("watchdog keep differs from low-speed osc");
	a_stop_sample: assert property (smp_all_dis == !lsosc_run)
		else $error("sampling disable wrong");
	a_deep_i2c: assert property (i2c_wake_en |-> !keep_fast_periph)
		else $error("i2c wake with fast peripherals");
	a_low_volt: assert property (core_supply_voltage == SBG_V115 |-> i2c_wake_en)
		else $error("low core voltage outside deep mode");
	a_volt_drop: assert property ($past(rst) |-> ##[1:2] core_supply_voltage == SBG_V145)
		else $error("core voltage did not drop");
endmodule // sbg_gating_chk
bind sbg_gating sbg_gating_chk u_chk (.clk(clk), .rst(rst), .avs_read(avs_read),
	.avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .per_sel(per_sel),
	.per_write(per_write), .per_read(per_read), .per_write_ok(per_write_ok),
	.per_read_ok(per_read_ok), .per_clk_en(per_clk_en), .per_rst(per_rst), .pll_run(pll_run),
	.lsosc_run(lsosc_run), .keep_wdt_ltb(keep_wdt_ltb), .keep_fast_periph(keep_fast_periph),
	.smp_all_dis(smp_all_dis), .i2c_wake_en(i2c_wake_en),
	.core_supply_voltage(core_supply_voltage));

// ### tb_sbg_gating.sv
`timescale 1ns/100ps
module tb_sbg_gating
	import sbg_pkg::*;
();
	logic clk = 1'b0, rst = 1'b1, rd = 1'b0, we = 1'b0, pw = 1'b0, pr = 1'b0;
	logic wk = 1'b0, im = 1'b0, saw = 1'b0;
	logic [5:0] adr = 6'h0;
	logic [4:0] sel = 5'h0;
	logic [31:0] wd = 32'h0, rdata, cken, prst, q;
	logic wait_n, wok, rok, pcr, pll, ls, wdt, voltage_level_supervisor, fst, fdis, adis, i2w, cpu;
	logic [1:0] volt;
	int num_errors = 0, cmp_count = 0;
	sbg_gating #(.PLL_RAMP_CYC(20), .WAKE_HALT_CYC(40), .WAKE_HALTD_CYC(40),
		.WAKE_STOP_CYC(40)) DUT (.clk(clk), .rst(rst), .avs_address(adr), .avs_read(rd),
		.avs_write(we), .avs_writedata(wd), .avs_readdata(rdata), .avs_waitrequest(wait_n),
		.per_sel(sel), .per_write(pw), .per_read(pr), .per_write_ok(wok), .per_read_ok(rok),
		.wake_pin(wk), .i2c_addr_match(im), .per_clk_en(cken), .per_rst(prst),
		.port_cfg_rst(pcr), .pll_run(pll), .lsosc_run(ls), .keep_wdt_ltb(wdt), .keep_vls(voltage_level_supervisor),
		.keep_fast_periph(fst), .smp_fast_dis(fdis), .smp_all_dis(adis), .i2c_wake_en(i2w),
		.core_supply_voltage(volt), .cpu_clk_ready(cpu));
	// clock and software reset pulse watcher
	initial forever #5 clk = ~clk;
	always @(posedge clk) if (pcr === 1'b1) saw <= 1'b1;
	task automatic check(input string nm, input logic [31:0] seen, exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// one bus cycle, held until waitrequest is seen low
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		@(posedge clk);
		adr <= a;
		we <= w;
		rd <= !w;
		wd <= d;
		@(negedge clk);
		while (wait_n !== 1'b0) @(negedge clk);
		@(posedge clk);
		q = rdata;
		we <= 1'b0;
		rd <= 1'b0;
		repeat (2) @(negedge clk);
	endtask
	task automatic per_try(input logic [4:0] s, input logic w, input logic exp);
		@(posedge clk);
		sel <= s;
		pw <= w;
		pr <= !w;
		@(posedge clk);
		pw <= 1'b0;
		pr <= 1'b0;
		@(negedge clk);
		check(w ? "write_ok" : "read_ok", w ? wok : rok, exp);
	endtask
	task automatic t_reset();
		check("clk_en", cken, 32'h0);
		check("per_rst", prst, 32'hFFFFFFFF);
		bus(1'b0, SBG_OFF_CKS3, 32'h0);
		check("cks3", q, {24'h0, SBG_GATE_RST});
		bus(1'b0, 6'h30, 32'h0);
		check("unmapped", q, 32'h0);
	endtask
	task automatic t_groups();
		for (int g = 0; g < 4; g++) begin
			bus(1'b1, SBG_OFF_CKS0 + 6'(4 * g), 32'h0);
			check("clk_on", cken[g*8+:8], 8'hFF);
			bus(1'b1, SBG_OFF_RST0 + 6'(4 * g), 32'hF0);
			check("rst_f0", prst[g*8+:8], 8'hF0);
			bus(1'b1, SBG_OFF_RST0 + 6'(4 * g), 32'h10F);
			check("rst_0f", prst[g*8+:8], 8'h0F);
			check("clk_kept", cken[g*8+:8], 8'hFF);
			bus(1'b0, SBG_OFF_RST0 + 6'(4 * g), 32'h0);
			check("rst_rd", q, 32'h0F);
		end
	endtask
	task automatic t_access();
		per_try(5'd4, 1'b1, 1'b1);
		per_try(5'd0, 1'b1, 1'b0);
		per_try(5'd16, 1'b0, 1'b1);
		per_try(5'd20, 1'b0, 1'b1);
		bus(1'b1, SBG_OFF_CKS2, 32'h10);
		check("uart_clk", cken[20], 1'b0);
		per_try(5'd20, 1'b0, 1'b0);
		per_try(5'd20, 1'b1, 1'b0);
	endtask
	task automatic t_swrst();
		saw = 1'b0;
		bus(1'b1, SBG_OFF_SWRST, 32'h1);
		check("all_rst", prst, 32'hFFFFFFFF);
		repeat (2) @(negedge clk);
		check("port_cfg", saw, 1'b1);
	endtask
	// expected {pll,ls,wdt,vls,fast,all_dis,i2c,fast_dis} for modes 1..5
	task automatic t_modes();
		logic [7:0] ex [5] = '{8'hF8, 8'h79, 8'h73, 8'h17, 8'h17};
		logic [1:0] ev [5] = '{SBG_V155, SBG_V155, SBG_V115, SBG_V155, SBG_V115};
		for (int i = 0; i < 5; i++) begin
			// no lcd here, so the display-off steps before deep modes are already met
			bus(1'b1, SBG_OFF_MODE, 32'(i + 1) | 32'h10);
			check("mode_out", {pll, ls, wdt, voltage_level_supervisor, fst, adis, i2w, fdis}, ex[i]);
			check("volt", volt, ev[i]);
			check("cpu_wait", cpu, 1'b0);
			if (i > 1) im <= 1'b1;
			else wk <= 1'b1;
			repeat (4) @(posedge clk);
			im <= 1'b0;
			wk <= 1'b0;
			repeat (100) @(posedge clk);
			@(negedge clk);
			check("cpu_back", cpu, 1'b1);
		end
	endtask
	task automatic close_out();
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		t_reset();
		t_groups();
		t_access();
		t_swrst();
		t_modes();
		close_out();
	end
	// watchdog
	initial begin
		#200000;
		num_errors++;
		close_out();
	end
endmodule // tb_sbg_gating
